// File: qrf_formatter.sv
// Quadlet receive formatter writing token, header and data into the receive FIFO.
`timescale 1ns/1ps
`default_nettype none
module qrf_formatter (
	input wire logic core_clk_i, // System clock, 100 MHz.
	input wire logic reset_n_i, // Asynchronous reset, active low.
	input wire logic pkt_valid_i, // Received packet offered, level.
	output logic pkt_ready_o, // Packet can be accepted this cycle.
	input wire logic [31:0] hdr0_i, // Dest ID, tLabel, rt, tCode, priority.
	input wire logic [31:0] hdr1_i, // Source ID and offset high.
	input wire logic [31:0] hdr2_i, // Offset low.
	input wire logic [31:0] data_i, // Quadlet data.
	input wire logic [1:0] spd_i, // Received speed code.
	input wire logic [3:0] ack_sent_i, // Acknowledge returned for the packet.
	input wire logic cable_mode_i, // High in cable systems.
	output logic [31:0] fifo_data_o, // Quadlet to the receive FIFO.
	output logic fifo_valid_o, // Quadlet write strobe.
	input wire logic fifo_ready_i, // FIFO can take a quadlet.
	output logic fifo_last_o, // Marks the final quadlet of a packet.
	output logic hdr_err_o // Registered misalignment or priority fault.
);
	// ****************************************
	// Packet capture
	// ****************************************
	qrf_pkg::qrf_state_t state;
	logic [31:0] word [0:4];
	logic [2:0] idx;
	logic [2:0] nwords;
	logic [3:0] tcode;
	logic has_data;
	logic [31:0] tok;

	assign tcode = hdr0_i[7:4];
	assign has_data = (tcode == qrf_pkg::TC_WR_QUAD) || (tcode == qrf_pkg::TC_RD_RESP);
	// The whole packet is taken in one cycle, but only in idle, so at least one empty cycle separates packets on the stream.
	assign pkt_ready_o = (state == qrf_pkg::QRF_IDLE);

	always_comb begin
		tok = 32'h0;
		tok[qrf_pkg::TOK_COMPLETE_POS] = 1'b1;
		tok[qrf_pkg::TOK_SPD_POS +: 2] = spd_i;
		tok[qrf_pkg::TOK_CNT_POS +: 8] = has_data ? 8'h01 : 8'h00;
		tok[qrf_pkg::TOK_TCODE_POS +: 4] = tcode;
		tok[qrf_pkg::TOK_ACK_POS +: 4] = ack_sent_i;
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			for (int i = 0; i < 5; i++) begin
				word[i] <= 32'h0;
			end
			nwords <= 3'h0;
		end else if (pkt_valid_i && pkt_ready_o) begin
			word[0] <= tok;
			// Header fields pass through untouched so label, retry and code survive.
			word[1] <= hdr0_i;
			word[2] <= hdr1_i;
			word[3] <= hdr2_i;
			word[4] <= data_i;
			nwords <= has_data ? qrf_pkg::WORDS_DATA : qrf_pkg::WORDS_NO_DATA;
		end
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			hdr_err_o <= 1'b0;
		end else if (pkt_valid_i && pkt_ready_o) begin
			hdr_err_o <= (hdr2_i[1:0] != 2'h0) || (cable_mode_i && hdr0_i[3:0] != 4'h0);
		end
	end

	// ****************************************
	// FIFO write sequencing
	// ****************************************
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state <= qrf_pkg::QRF_IDLE;
			idx <= 3'h0;
		end else begin
			unique case (state)
				qrf_pkg::QRF_IDLE: begin
					if (pkt_valid_i) begin
						state <= qrf_pkg::QRF_SEND;
						idx <= 3'h0;
					end
				end
				qrf_pkg::QRF_SEND: begin
					if (fifo_ready_i) begin
						if (idx == nwords - 3'h1) begin
							state <= qrf_pkg::QRF_IDLE;
						end
						idx <= idx + 3'h1;
					end
				end
				default: state <= qrf_pkg::QRF_IDLE;
			endcase
		end
	end

	assign fifo_valid_o = (state == qrf_pkg::QRF_SEND);
	assign fifo_last_o = fifo_valid_o && (idx == nwords - 3'h1);

	// The quadlet leaves from a register so the FIFO never sees the index mux settle.
	// The next word is fetched on each accepted beat but the last, so no cycle is lost for it.
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			fifo_data_o <= 32'h0;
		end else if (pkt_valid_i && pkt_ready_o) begin
			fifo_data_o <= tok;
		end else if (fifo_valid_o && fifo_ready_i && !fifo_last_o) begin
			fifo_data_o <= word[idx + 3'h1];
		end
	end

	// ****************************************
	// Stream checks
	// ****************************************
	sequence s_take;
		pkt_valid_i && pkt_ready_o;
	endsequence

	sequence s_beat;
		fifo_valid_o && fifo_ready_i;
	endsequence

	sequence s_stall;
		fifo_valid_o && !fifo_ready_i;
	endsequence

	sequence s_last_beat;
		fifo_valid_o && fifo_ready_i && fifo_last_o;
	endsequence

	sequence s_token_shown;
		fifo_valid_o && idx == 3'h0;
	endsequence

	a_token_first: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		s_take |=> fifo_valid_o && idx == 3'h0)
		else $error("token not first");

	a_no_data_len: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		fifo_last_o && !word[0][qrf_pkg::TOK_CNT_POS] |-> idx == 3'h3)
		else $error("dataless packet length wrong");

	a_data_len: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		fifo_last_o && word[0][qrf_pkg::TOK_CNT_POS] |-> idx == 3'h4)
		else $error("data packet length wrong");

	a_in_order: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		fifo_valid_o && fifo_ready_i && !fifo_last_o |=> fifo_valid_o && idx == $past(idx) + 3'h1)
		else $error("quadlet order broken");

	a_hold_stall: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		fifo_valid_o && !fifo_ready_i |=> $stable(fifo_data_o) && fifo_valid_o)
		else $error("data changed under stall");

	a_complete_set: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		fifo_valid_o && idx == 3'h0 |-> fifo_data_o[qrf_pkg::TOK_COMPLETE_POS])
		else $error("packet complete flag clear");

	a_out_matches: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		fifo_valid_o |-> fifo_data_o == word[idx])
		else $error("shown quadlet differs from stored word");

	a_busy_refuse: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		fifo_valid_o |-> !pkt_ready_o)
		else $error("packet accepted while sending");

	a_idle_quiet: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		pkt_ready_o |-> !fifo_valid_o && !fifo_last_o)
		else $error("stream active while idle");

	a_ready_return: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		s_last_beat |=> pkt_ready_o && !fifo_valid_o)
		else $error("not idle after last quadlet");

	a_token_walk: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		s_take ##1 (s_token_shown and s_beat) |=> fifo_valid_o && idx == 3'h1 && fifo_data_o == word[1])
		else $error("header did not follow token");

	a_stall_index: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		s_stall |=> idx == $past(idx))
		else $error("index moved under stall");

	a_stall_last: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		s_stall and fifo_last_o |=> fifo_last_o)
		else $error("last marker dropped under stall");

	a_length_bound: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		fifo_valid_o |-> idx < nwords)
		else $error("index beyond packet length");

	a_data_shown: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		fifo_valid_o && idx == 3'h4 |-> fifo_last_o && word[0][qrf_pkg::TOK_CNT_POS])
		else $error("data quadlet without count");

	// ****************************************
	// Header checks
	// ****************************************
	// The stored words are checked one cycle after the take, since the host may
	// stall the stream for a long time before it reads them.
	a_speed_kept: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		s_take |=> word[0][qrf_pkg::TOK_SPD_POS +: 2] == $past(spd_i))
		else $error("speed lost");

	a_ack_kept: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		s_take |=> word[0][qrf_pkg::TOK_ACK_POS +: 4] == $past(ack_sent_i))
		else $error("ack lost");

	a_header_kept: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		s_take |=> word[1] == $past(hdr0_i) && word[2] == $past(hdr1_i))
		else $error("header lost");

	a_offset_kept: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		s_take |=> word[3] == $past(hdr2_i))
		else $error("offset low lost");

	a_data_kept: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		s_take and (hdr0_i[7:4] == qrf_pkg::TC_WR_QUAD || hdr0_i[7:4] == qrf_pkg::TC_RD_RESP)
		|=> word[4] == $past(data_i))
		else $error("data quadlet lost");

	a_count_field: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		s_take |=> word[0][qrf_pkg::TOK_CNT_POS +: 8] ==
		((nwords == qrf_pkg::WORDS_DATA) ? 8'h01 : 8'h00))
		else $error("count field disagrees with length");

	a_token_tcode: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		s_token_shown |-> fifo_data_o[qrf_pkg::TOK_TCODE_POS +: 4] == word[1][7:4])
		else $error("token code differs from header");

	a_token_spare: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		s_token_shown |-> fifo_data_o[31:21] == 11'h0 && fifo_data_o[19:18] == 2'h0)
		else $error("token spare bits set");

	a_dest_kept: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		s_take |=> word[1][31:16] == $past(hdr0_i[31:16]))
		else $error("destination lost");

	a_label_kept: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		s_take |=> word[1][15:10] == $past(hdr0_i[15:10]))
		else $error("transaction label lost");

	a_retry_kept: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		s_take |=> word[1][9:8] == $past(hdr0_i[9:8]))
		else $error("retry code lost");

	a_source_kept: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		s_take |=> word[2][31:16] == $past(hdr1_i[31:16]))
		else $error("source lost");

	a_rcode_kept: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		s_take |=> word[2][15:12] == $past(hdr1_i[15:12]))
		else $error("response code lost");

	a_align_flag: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		s_take and hdr2_i[1:0] != 2'h0 |=> hdr_err_o)
		else $error("misalignment missed");

	a_priority_flag: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		s_take and (cable_mode_i && hdr0_i[3:0] != 4'h0) |=> hdr_err_o)
		else $error("cable priority fault missed");

	a_clean_header: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		s_take and (hdr2_i[1:0] == 2'h0 && (!cable_mode_i || hdr0_i[3:0] == 4'h0))
		|=> !hdr_err_o)
		else $error("false header fault");

	a_flag_steady: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		!pkt_ready_o |=> $stable(hdr_err_o))
		else $error("fault flag moved while sending");
endmodule
`default_nettype wire

// File: qrf_formatter_tb.sv
// Testbench for the quadlet receive formatter.
`timescale 1ns/1ps
`default_nettype none
module qrf_formatter_tb;
	logic clk = 0, rst_n = 0, pv = 0, cab = 1, slow = 0, rdy, fv, fl, fr, he;
	logic [31:0] h0 = 0, h1 = 0, h2 = 0, dt = 0, fd;
	logic [31:0] q [5];
	logic [1:0] sp = 0;
	logic [3:0] ak = 0;
	int len, pk, err_total = 0, checks = 0;
	qrf_formatter dut_u (.core_clk_i(clk), .reset_n_i(rst_n), .pkt_valid_i(pv),
		.pkt_ready_o(rdy), .hdr0_i(h0), .hdr1_i(h1), .hdr2_i(h2), .data_i(dt),
		.spd_i(sp), .ack_sent_i(ak), .cable_mode_i(cab), .fifo_data_o(fd),
		.fifo_valid_o(fv), .fifo_ready_i(fr), .fifo_last_o(fl), .hdr_err_o(he));
	qrf_host_model host_u (.clk_i(clk), .reset_n_i(rst_n), .slow_i(slow),
		.valid_i(fv), .data_i(fd), .last_i(fl), .ready_o(fr), .q_o(q),
		.len_o(len), .pk_o(pk));
	initial forever #5 clk = ~clk;
	task chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			err_total++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task end_sim();
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task send(input logic [3:0] tc, input logic [3:0] pri, input logic [31:0] lo);
		int t;
		int p0;
		logic d;
		d = (tc == qrf_pkg::TC_WR_QUAD) || (tc == qrf_pkg::TC_RD_RESP);
		p0 = pk;
		h0 = {10'h2a5, 6'h13, 6'h2d, 2'h2, tc, pri};
		h1 = 32'hffc1_a123;
		h2 = lo;
		dt = ~lo;
		ak = tc ^ 4'h9;
		for (t = 0; t < 50 && rdy !== 1'b1; t++) @(negedge clk);
		if (rdy !== 1'b1) begin
			err_total++;
			end_sim();
		end else begin
			pv = 1;
			@(negedge clk);
			pv = 0;
			for (t = 0; t < 50 && pk == p0; t++) @(negedge clk);
			if (pk == p0) begin
				err_total++;
				end_sim();
			end else begin
				chk(len, d ? 5 : 4);
				chk(q[0], {11'h0, 1'b1, 2'h0, sp, 7'h0, d, tc, ak});
				chk(q[1], h0);
				chk(q[2], h1);
				chk(q[3], h2);
				if (d) chk(q[4], dt);
				chk(he, (lo[1:0] != 0) || (cab && pri != 0));
			end
		end
	endtask
	// Reset in mid-packet must drop the stream and the fault flag at once.
	task run_reset();
		slow = 1;
		h2 = 32'h0000_2003;
		pv = 1;
		@(negedge clk);
		pv = 0;
		repeat (3) @(negedge clk);
		chk(fv, 1);
		chk(he, 1);
		rst_n = 0;
		repeat (2) @(negedge clk);
		chk({rdy, fv, fl, he}, 4'h8);
		chk(fd, 0);
		rst_n = 1;
		send(qrf_pkg::TC_RD_RESP, 4'h0, 32'h0000_3004);
	endtask
	task run_types();
		for (int i = 0; i < 4; i++) begin
			sp = 2'(i % 3);
			slow = i[0];
			send(4'(2 * i), 4'h0, 32'hbeef_0010);
		end
	endtask
	task run_faults();
		send(qrf_pkg::TC_WR_QUAD, 4'h0, 32'h0000_1002);
		send(qrf_pkg::TC_RD_QUAD, 4'h5, 32'h0000_1000);
		cab = 0;
		send(qrf_pkg::TC_RD_QUAD, 4'h5, 32'h0000_1000);
	endtask
	initial begin
		repeat (2) @(negedge clk);
		rst_n = 1;
		run_types();
		run_faults();
		run_reset();
		end_sim();
	end
endmodule
`default_nettype wire

// File: qrf_host_model.sv
// Host model draining the receive FIFO, with optional stalls.
`timescale 1ns/1ps
`default_nettype none
module qrf_host_model (
	input wire logic clk_i, // Clock.
	input wire logic reset_n_i, // Reset, active low.
	input wire logic slow_i, // Stall every other cycle.
	input wire logic valid_i, // Quadlet offered.
	input wire logic [31:0] data_i, // Quadlet.
	input wire logic last_i, // Final quadlet.
	output logic ready_o, // Quadlet can be taken.
	output logic [31:0] q_o [5], // Quadlets of last packet.
	output int len_o, // Quadlets in last packet.
	output int pk_o // Packets taken.
);
	int n;
	// Stalling alternates ready so each quadlet that follows an accepted one must stand across a refused edge.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ready_o <= 1'b0;
			n <= 0;
			len_o <= 0;
			pk_o <= 0;
		end else begin
			ready_o <= !slow_i || !ready_o;
			if (valid_i && ready_o) begin
				q_o[n] <= data_i;
				n <= last_i ? 0 : n + 1;
				if (last_i) begin
					len_o <= n + 1;
					pk_o <= pk_o + 1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// File: qrf_pkg.sv
// Constants and layout of the quadlet receive formatter.
// Function
// - First stored quadlet is a status token the device builds itself.
// - Second quadlet: destination ID upper 16 bits, packet control lower 16 bits.
// - Third quadlet: source ID upper half; low half plus fourth form 48-bit offset.
// - Data quadlet stored only for write requests and read responses.
// - Token packet-complete flag 1 means this block ends the packet.
// - Token speed code 00/01/10 for 100/200/400 Mbit/s; 11 undefined.
// - Token carries the count of data quadlets stored.
// - Token carries the acknowledge code sent for the packet.
// - Destination ID is 10-bit bus number joined to 6-bit node number.
// - Transaction label is kept unchanged in the header.
// - Two-bit retry code is kept as received.
// - Priority bits are zero in cable systems.
// - The 48-bit offset is quadlet aligned, low two bits zero.
// - Lock responses carry response code in offset-high upper four bits.
package qrf_pkg;
	// Transaction codes of the four quadlet packet types.
	localparam logic [3:0] TC_WR_QUAD = 4'h0;
	localparam logic [3:0] TC_WR_RESP = 4'h2;
	localparam logic [3:0] TC_RD_QUAD = 4'h4;
	localparam logic [3:0] TC_RD_RESP = 4'h6;
	// Speed codes.
	localparam logic [1:0] SPD_100 = 2'h0;
	localparam logic [1:0] SPD_200 = 2'h1;
	localparam logic [1:0] SPD_400 = 2'h2;
	// Token field positions (bit 0 is the least significant bit).
	localparam int TOK_COMPLETE_POS = 20;
	localparam int TOK_SPD_POS = 16;
	localparam int TOK_CNT_POS = 8;
	localparam int TOK_TCODE_POS = 4;
	localparam int TOK_ACK_POS = 0;
	localparam logic [2:0] WORDS_NO_DATA = 3'h4;
	localparam logic [2:0] WORDS_DATA = 3'h5;
	typedef enum logic [1:0] {QRF_IDLE, QRF_SEND} qrf_state_t;
endpackage
